/* File: hdl/tcbe_bit_buf.sv */
`timescale 1ns/1ps
// two-entry skid buffer: a stalled encoder loses no bit
module tcbe_bit_buf #(
  parameter int W = 2
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_reg [0:1];
  logic         wr_ptr_reg;
  logic         rd_ptr_reg;
  logic [1:0]   count_reg;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_reg[wr_ptr_reg] <= in_data;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

/* File: hdl/tcbe_core.sv */
`timescale 1ns/1ps
module tcbe_core #(
  parameter int HALF_CYC  = tcbe_pkg::HALF_BIT_CYC,
  parameter int BULK_BITS = tcbe_pkg::BULK_DEF_BITS
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        supply_good,
  input  wire logic        sym_valid,
  input  wire logic [3:0]  sym_data,
  input  wire logic        sym_last,
  input  wire logic        req_valid,
  input  wire tcbe_pkg::tcbe_req_s req,
  output logic             req_ready,
  input  wire logic        nvm_done,
  output logic             nvm_wr,
  output logic [3:0]       nvm_blk,
  output logic [31:0]      nvm_wdata,
  output logic [15:0]      nvm_wcrc,
  input  wire logic [31:0] blk_data,
  input  wire logic [15:0] blk_crc,
  output logic [3:0]       rd_blk,
  output logic             cmd_crc_ok,
  output logic             cmd_dropped,
  output logic [3:0]       cmd_sym,
  output logic             cmd_sym_valid,
  output logic             mod_on,
  output logic             tx_busy,
  output logic             tsf_mode,
  output logic             bulk_en
);
  // power-good is asynchronous to the core: two flops then gate reset
  logic       pg_s1_reg;
  logic       pg_s2_reg;
  logic       rst;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pg_s1_reg <= 1'b0;
      pg_s2_reg <= 1'b0;
    end
    else
    begin
      pg_s1_reg <= supply_good;
      pg_s2_reg <= pg_s1_reg;
    end
  end
  assign rst = sys_rst || !pg_s2_reg;

  // crc step over one bit, msb first
  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    crc_bit = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? tcbe_pkg::CRC_POLY : 16'h0000);
  endfunction

  // incoming symbols fan out to the decoder and the checker
  logic [15:0] rx_crc_reg;
  logic [15:0] rx_crc_next;
  logic        rx_done_reg;
  logic        rx_ok_reg;
  always_comb
  begin
    rx_crc_next = rx_crc_reg;
    for (int i = 3; i >= 0; i--)
      rx_crc_next = crc_bit(rx_crc_next, sym_data[i]);
  end
  assign cmd_sym       = sym_data;
  assign cmd_sym_valid = sym_valid;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rx_crc_reg  <= tcbe_pkg::CRC_PRESET;
      rx_done_reg <= 1'b0;
      rx_ok_reg   <= 1'b0;
    end
    else if (sym_valid)
    begin
      rx_crc_reg  <= sym_last ? tcbe_pkg::CRC_PRESET : rx_crc_next;
      rx_done_reg <= sym_last;
      rx_ok_reg   <= (rx_crc_next == tcbe_pkg::CRC_RESIDUE_OK);
    end
    else
      rx_done_reg <= 1'b0;
  end
  assign cmd_crc_ok = rx_ok_reg;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'h0,
    ST_WRITE = 3'h1,
    ST_LOAD  = 3'h2,
    ST_CALC  = 3'h3,
    ST_SEND  = 3'h4,
    ST_WAIT  = 3'h5
  } tcbe_st_e;

  tcbe_st_e           st_reg;
  tcbe_pkg::tcbe_req_s cur_reg;
  logic               ok_latch_reg;
  logic               tsf_reg;
  logic               bre_reg;
  logic [31:0]        wp_reg;
  logic [31:0]        cfg_reg;
  logic [191:0]       shreg_reg;
  logic [7:0]         bits_left_reg;
  logic [5:0]         calc_cnt_reg;
  logic [15:0]        computed_check_value_reg;
  logic [1:0]         bulk_idx_reg;
  logic               drop_reg;

  // latch the check verdict until the request arrives
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ok_latch_reg <= 1'b0;
    else if (rx_done_reg)
      ok_latch_reg <= rx_ok_reg;
    else if (req_valid && req_ready)
      ok_latch_reg <= 1'b0;
  end

  // no request is taken while the core is still held in reset
  assign req_ready = (st_reg == ST_IDLE) && pg_s2_reg;
  wire accept   = req_valid && req_ready;
  wire good     = ok_latch_reg || rx_done_reg && rx_ok_reg;
  wire is_wr    = req.cmd == tcbe_pkg::TCBE_CMD_WRITE;

  // masked write data: protection block only gains bits
  logic [31:0] wmask;
  logic [31:0] wdata_eff;
  assign wmask = (req.blk == 4'(tcbe_pkg::BLK_CFG)) && (wp_reg[tcbe_pkg::BLK_CFG] == 1'b1) ?
                 ((32'h1 << tcbe_pkg::TSF_BIT) | (32'h1 << tcbe_pkg::BRE_BIT)) :
                 32'hFFFFFFFF;
  assign wdata_eff = (req.blk == 4'(tcbe_pkg::BLK_WP)) ? (req.data | wp_reg) :
                     ((req.data & wmask) | (cfg_reg & ~wmask));

  wire send_fresh = (cur_reg.blk == 4'(tcbe_pkg::BLK_CFG)) ||
                    (cur_reg.blk == 4'(tcbe_pkg::BLK_WP));

  // outgoing bit stream feeds the buffer
  tcbe_pkg::tcbe_bit_s src_bit;
  logic                src_valid;
  logic                src_ready;
  tcbe_pkg::tcbe_bit_s enc_bit;
  logic                enc_valid;
  logic                enc_ready;
  assign src_bit.bit_val = shreg_reg[191];
  assign src_bit.last    = (bits_left_reg == 8'h01);
  assign src_valid       = (st_reg == ST_SEND);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg        <= ST_IDLE;
      cur_reg       <= '0;
      tsf_reg       <= 1'b0;
      bre_reg       <= 1'b0;
      wp_reg        <= 32'h0;
      cfg_reg       <= 32'h0;
      shreg_reg     <= '0;
      bits_left_reg <= 8'h00;
      calc_cnt_reg  <= 6'h00;
      computed_check_value_reg      <= tcbe_pkg::CRC_PRESET;
      bulk_idx_reg  <= 2'h0;
      drop_reg      <= 1'b0;
    end
    else
    begin
      drop_reg <= 1'b0;
      case (st_reg)
        ST_IDLE:
          if (accept)
          begin
            cur_reg <= req;
            if (req.cmd == tcbe_pkg::TCBE_CMD_BULK)
            begin
              bulk_idx_reg <= 2'h0;
              st_reg       <= ST_LOAD;
            end
            else if (!is_wr)
              st_reg <= ST_LOAD;
            else if (!good)
              drop_reg <= 1'b1;
            else
            begin
              cur_reg.data <= wdata_eff;
              st_reg       <= ST_WRITE;
              if (req.blk == 4'(tcbe_pkg::BLK_WP))
                wp_reg <= wdata_eff;
              if (req.blk == 4'(tcbe_pkg::BLK_CFG))
              begin
                cfg_reg <= wdata_eff;
                tsf_reg <= wdata_eff[tcbe_pkg::TSF_BIT];
                bre_reg <= wdata_eff[tcbe_pkg::BRE_BIT];
              end
            end
          end
        ST_WRITE:
          if (nvm_done)
            st_reg <= ST_LOAD;
        ST_LOAD:
          if (cur_reg.cmd == tcbe_pkg::TCBE_CMD_BULK)
          begin
            // id, field blocks, then block0 low half as the check field
            shreg_reg     <= {shreg_reg[159:0], blk_data};
            bulk_idx_reg  <= bulk_idx_reg + 2'h1;
            if (bulk_idx_reg == 2'h3)
            begin
              shreg_reg     <= {shreg_reg[159:0], blk_data} << (192 - 128);
              bits_left_reg <= 8'(BULK_BITS);
              st_reg        <= ST_WAIT;
            end
          end
          else if (send_fresh)
          begin
            shreg_reg    <= {blk_data, 160'h0};
            computed_check_value_reg     <= tcbe_pkg::CRC_PRESET;
            calc_cnt_reg <= 6'h00;
            st_reg       <= ST_CALC;
          end
          else
          begin
            shreg_reg     <= {blk_data, blk_crc, 144'h0};
            bits_left_reg <= 8'(tcbe_pkg::BLK_BITS + tcbe_pkg::CRC_BITS);
            st_reg        <= ST_SEND;
          end
        ST_WAIT:
        begin
          // the check slot is overwritten, not merged with field bits
          shreg_reg <= (shreg_reg & ~({176'h0, 16'hFFFF} << (192 - BULK_BITS))) |
                       ({176'h0, blk_data[15:0]} << (192 - BULK_BITS));
          st_reg    <= ST_SEND;
        end
        ST_CALC:
        begin
          computed_check_value_reg     <= crc_bit(computed_check_value_reg, shreg_reg[191 - 32'(calc_cnt_reg)]);
          calc_cnt_reg <= calc_cnt_reg + 6'h01;
          if (calc_cnt_reg == 6'(tcbe_pkg::BLK_BITS - 1))
          begin
            shreg_reg[159:144] <= crc_bit(computed_check_value_reg, shreg_reg[160]);
            bits_left_reg      <= 8'(tcbe_pkg::BLK_BITS + tcbe_pkg::CRC_BITS);
            st_reg             <= ST_SEND;
          end
        end
        ST_SEND:
          if (src_ready)
          begin
            shreg_reg     <= {shreg_reg[190:0], 1'b0};
            bits_left_reg <= bits_left_reg - 8'h01;
            if (bits_left_reg == 8'h01)
              st_reg <= ST_IDLE;
          end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  // block read address per phase
  logic [3:0] bulk_blk;
  assign bulk_blk = (bulk_idx_reg == 2'h0) ? 4'(tcbe_pkg::BLK_ID) :
                    4'(tcbe_pkg::BLK_FIELD0) + {2'h0, bulk_idx_reg} - 4'h1;
  assign rd_blk = (st_reg == ST_WAIT) ? 4'(tcbe_pkg::BLK_CFG) :
                  (cur_reg.cmd == tcbe_pkg::TCBE_CMD_BULK) ? bulk_blk : cur_reg.blk;

  assign nvm_wr      = (st_reg == ST_WRITE);
  assign nvm_blk     = cur_reg.blk;
  assign nvm_wdata   = cur_reg.data;
  assign nvm_wcrc    = cur_reg.crc;
  assign cmd_dropped = drop_reg;
  assign tsf_mode    = tsf_reg;
  assign bulk_en     = bre_reg;

  tcbe_bit_buf #(
    .W (2)
  ) u_buf (
    .core_clk  (core_clk),
    .rst       (rst),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .in_data   (src_bit),
    .out_valid (enc_valid),
    .out_ready (enc_ready),
    .out_data  (enc_bit)
  );

  // biphase encoder: half 0 cloaks for a zero, half 1 cloaks for a one
  logic        enc_act_reg;
  logic        enc_val_reg;
  logic        enc_half_reg;
  logic [15:0] enc_cnt_reg;
  logic        mod_reg;
  wire         half_end = (enc_cnt_reg == 16'(HALF_CYC - 1));
  assign enc_ready = !enc_act_reg || (enc_half_reg && half_end);
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      enc_act_reg  <= 1'b0;
      enc_val_reg  <= 1'b0;
      enc_half_reg <= 1'b0;
      enc_cnt_reg  <= 16'h0000;
      mod_reg      <= 1'b0;
    end
    else if (enc_ready && enc_valid)
    begin
      enc_act_reg  <= 1'b1;
      enc_val_reg  <= enc_bit.bit_val;
      enc_half_reg <= 1'b0;
      enc_cnt_reg  <= 16'h0000;
      mod_reg      <= !enc_bit.bit_val;
    end
    else if (enc_act_reg)
    begin
      enc_cnt_reg <= half_end ? 16'h0000 : enc_cnt_reg + 16'h0001;
      if (half_end && !enc_half_reg)
      begin
        enc_half_reg <= 1'b1;
        mod_reg      <= enc_val_reg;
      end
      else if (half_end)
      begin
        enc_act_reg <= 1'b0;
        mod_reg     <= 1'b0;
      end
    end
  end
  assign mod_on  = mod_reg;
  assign tx_busy = enc_act_reg || enc_valid || (st_reg != ST_IDLE);
endmodule

/* File: inc/tcbe_pkg.sv */
package tcbe_pkg;
  localparam int          CLK_HZ          = 25000000;
  localparam int          HALF_BIT_NS     = 7000;
  localparam int          HALF_BIT_CYC    = (HALF_BIT_NS * (CLK_HZ / 1000000)) / 1000;
  localparam logic [15:0] CRC_PRESET      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY        = 16'h1021;
  localparam logic [15:0] CRC_RESIDUE_OK  = 16'h0000;
  localparam int          TSF_BIT         = 30;
  localparam int          BRE_BIT         = 31;
  localparam int          BLK_CFG         = 0;
  localparam int          BLK_ID          = 1;
  localparam int          BLK_WP          = 2;
  localparam int          BLK_FIELD0      = 3;
  localparam int          NUM_BLOCKS      = 16;
  localparam int          BULK_MAX_BITS   = 160;
  localparam int          BULK_DEF_BITS   = 96;
  localparam int          BLK_BITS        = 32;
  localparam int          CRC_BITS        = 16;

  typedef enum logic [1:0]
  {
    TCBE_CMD_READ  = 2'h0,
    TCBE_CMD_WRITE = 2'h1,
    TCBE_CMD_BULK  = 2'h2,
    TCBE_CMD_NONE  = 2'h3
  } tcbe_cmd_e;

  typedef struct packed
  {
    tcbe_cmd_e   cmd;
    logic [3:0]  blk;
    logic [31:0] data;
    logic [15:0] crc;
  } tcbe_req_s;

  typedef struct packed
  {
    logic        bit_val;
    logic        last;
  } tcbe_bit_s;
endpackage

/* File: test/tcbe_core_chk.sv */
`timescale 1ns/1ps
module tcbe_core_chk #(
  parameter int HALF_CYC = 4
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        supply_good,
  input wire logic        sym_valid,
  input wire logic        req_valid,
  input wire tcbe_pkg::tcbe_req_s req,
  input wire logic        req_ready,
  input wire logic        nvm_done,
  input wire logic        nvm_wr,
  input wire logic [3:0]  nvm_blk,
  input wire logic [31:0] nvm_wdata,
  input wire logic [3:0]  rd_blk,
  input wire logic        cmd_crc_ok,
  input wire logic        cmd_dropped,
  input wire logic        cmd_sym_valid,
  input wire logic        mod_on
);
  logic mod_q;
  int   run_q;
  logic take;
  logic wr_take;
  assign take    = req_valid && req_ready;
  // same-cycle symbol would make the stored verdict stale
  assign wr_take = take && req.cmd == tcbe_pkg::TCBE_CMD_WRITE && !sym_valid;
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mod_q <= 1'b0;
      run_q <= 0;
    end
    else
    begin
      mod_q <= mod_on;
      run_q <= (mod_on != mod_q) ? 1 : run_q + 1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_half_len;
    mod_q && !mod_on |-> run_q == HALF_CYC || run_q == 2 * HALF_CYC;
  endproperty
  a_half_len: assert property (p_half_len)
    else $error("modulator on-time is not one or two half bits");
  property p_take_once;
    take && req.cmd != tcbe_pkg::TCBE_CMD_WRITE |=> !req_ready;
  endproperty
  a_take_once: assert property (p_take_once)
    else $error("second request accepted while busy");
  property p_rd_load;
    take && req.cmd == tcbe_pkg::TCBE_CMD_READ |=> rd_blk == $past(req.blk);
  endproperty
  a_rd_load: assert property (p_rd_load)
    else $error("read block not addressed");
  // config and protection blocks are masked, checked by the two below
  property p_wr_go;
    wr_take && cmd_crc_ok |=> nvm_wr && nvm_blk == $past(req.blk) &&
      (nvm_blk == 4'h0 || nvm_blk == 4'h2 || nvm_wdata == $past(req.data));
  endproperty
  a_wr_go: assert property (p_wr_go)
    else $error("checked write not programmed");
  property p_wp_keep;
    wr_take && cmd_crc_ok && req.blk == 4'h2 |=>
      (nvm_wdata & $past(req.data)) == $past(req.data);
  endproperty
  a_wp_keep: assert property (p_wp_keep)
    else $error("protection write lost a requested bit");
  property p_cfg_free;
    wr_take && cmd_crc_ok && req.blk == 4'h0 |=> nvm_wdata[31:30] == $past(req.data[31:30]);
  endproperty
  a_cfg_free: assert property (p_cfg_free)
    else $error("talk-first or bulk-enable bit not programmed");
  property p_wr_hold;
    nvm_wr && !nvm_done |=> nvm_wr && $stable(nvm_wdata);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("program strobe or data dropped early");
  property p_drop;
    wr_take && !cmd_crc_ok |-> ##[0:2] cmd_dropped;
  endproperty
  a_drop: assert property (p_drop)
    else $error("bad write not discarded");
  property p_drop_quiet;
    cmd_dropped |-> !nvm_wr [*4];
  endproperty
  a_drop_quiet: assert property (p_drop_quiet)
    else $error("discarded write programmed");
  property p_sym_fwd;
    sym_valid |-> ##[0:1] cmd_sym_valid;
  endproperty
  a_sym_fwd: assert property (p_sym_fwd)
    else $error("symbol not forwarded to decoder");
  property p_no_supply;
    !supply_good [*4] |-> !mod_on && !nvm_wr && !req_ready;
  endproperty
  a_no_supply: assert property (p_no_supply)
    else $error("active without supply");
  c_write: cover property (wr_take && cmd_crc_ok);
  c_drop: cover property (cmd_dropped);
  c_bulk: cover property (take && req.cmd == tcbe_pkg::TCBE_CMD_BULK);
endmodule

bind tcbe_core tcbe_core_chk #(.HALF_CYC(HALF_CYC)) u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .supply_good(supply_good),
  .sym_valid(sym_valid), .req_valid(req_valid), .req(req), .req_ready(req_ready),
  .nvm_done(nvm_done), .nvm_wr(nvm_wr), .nvm_blk(nvm_blk), .nvm_wdata(nvm_wdata),
  .rd_blk(rd_blk), .cmd_crc_ok(cmd_crc_ok), .cmd_dropped(cmd_dropped),
  .cmd_sym_valid(cmd_sym_valid), .mod_on(mod_on)
);

/* File: test/tcbe_nvm_model.sv */
`timescale 1ns/1ps
// block store; a write lands a fixed number of cycles after the strobe
module tcbe_nvm_model #(
  parameter int WR_CYC = 20
) (
  input  wire logic        core_clk,
  input  wire logic        nvm_wr,
  input  wire logic [3:0]  nvm_blk,
  input  wire logic [31:0] nvm_wdata,
  input  wire logic [15:0] nvm_wcrc,
  input  wire logic [3:0]  rd_blk,
  output logic             nvm_done,
  output logic [31:0]      blk_data,
  output logic [15:0]      blk_crc
);
  logic [31:0] mem [16];
  logic [15:0] sc [16];
  int          cnt;
  initial
  begin
    nvm_done = 1'b0;
    cnt = 0;
    for (int i = 0; i < 16; i++)
    begin
      // config and protection blocks start blank, like the core's shadows
      mem[i] = (i == 0 || i == 2) ? 32'h0 : 32'h9E3779B9 * 32'(i + 1);
      sc[i]  = 16'h1D0F ^ 16'(i);
    end
  end
  assign blk_data = mem[rd_blk];
  assign blk_crc  = sc[rd_blk];
  always @(posedge core_clk)
  begin
    nvm_done <= 1'b0;
    cnt <= nvm_wr ? cnt + 1 : 0;
    if (nvm_wr && cnt == WR_CYC)
    begin
      mem[nvm_blk] <= nvm_wdata;
      sc[nvm_blk]  <= nvm_wcrc;
      nvm_done     <= 1'b1;
    end
  end
endmodule

/* File: test/test_tag_crc_and_biphase_encoder.sv */
`timescale 1ns/1ps
module test_tag_crc_and_biphase_encoder;
  localparam int HC = 4;
  localparam int BB = 96;
  logic core_clk = 1'b0, sys_rst = 1'b1, supply_good = 1'b0;
  logic sym_valid = 1'b0, sym_last = 1'b0, req_valid = 1'b0;
  logic [3:0] sym_data = 4'h0;
  tcbe_pkg::tcbe_req_s req = '0;
  logic req_ready, nvm_done, nvm_wr, cmd_crc_ok, cmd_dropped, mod_on;
  logic cmd_sym_valid, tx_busy, tsf_mode, bulk_en;
  logic [3:0] nvm_blk, rd_blk, cmd_sym;
  logic [31:0] nvm_wdata, blk_data, d;
  logic [15:0] nvm_wcrc, blk_crc;
  int err_total = 0;
  int checks = 0;
  integer seed = 32'hf4b5a64f;
  bit q[$];

  always #20 core_clk = ~core_clk;

  tcbe_core #(.HALF_CYC(HC), .BULK_BITS(BB)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .supply_good(supply_good), .sym_valid(sym_valid), .sym_data(sym_data),
    .sym_last(sym_last), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .nvm_done(nvm_done), .nvm_wr(nvm_wr), .nvm_blk(nvm_blk), .nvm_wdata(nvm_wdata),
    .nvm_wcrc(nvm_wcrc), .blk_data(blk_data), .blk_crc(blk_crc), .rd_blk(rd_blk),
    .cmd_crc_ok(cmd_crc_ok), .cmd_dropped(cmd_dropped), .cmd_sym(cmd_sym),
    .cmd_sym_valid(cmd_sym_valid), .mod_on(mod_on), .tx_busy(tx_busy),
    .tsf_mode(tsf_mode), .bulk_en(bulk_en));
  tcbe_nvm_model u_nvm (.core_clk(core_clk), .nvm_wr(nvm_wr), .nvm_blk(nvm_blk),
    .nvm_wdata(nvm_wdata), .nvm_wcrc(nvm_wcrc), .rd_blk(rd_blk), .nvm_done(nvm_done),
    .blk_data(blk_data), .blk_crc(blk_crc));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [15:0] crc16(input bit b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i])
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction

  task automatic push(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      q.push_back(v[i]);
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic send(input tcbe_pkg::tcbe_cmd_e c, input logic [3:0] b,
                      input logic [31:0] v, input logic [15:0] k);
    @(posedge core_clk);
    #1;
    req_valid = 1'b1;
    req = '{c, b, v, k};
    do @(negedge core_clk); while (req_ready !== 1'b1);
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
  endtask

  // sample each half bit in its middle, aligned on the first cloak
  task automatic recv;
    int n;
    n = 0;
    while (mod_on !== 1'b1 && n < 5000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(tx_busy, 1);
    repeat (HC / 2) @(negedge core_clk);
    for (int j = q[0]; j < 2 * q.size(); j++)
    begin
      chk(mod_on, (j % 2) ? q[j / 2] : !q[j / 2]);
      repeat (HC) @(negedge core_clk);
    end
    chk(tx_busy, 0);
    q.delete();
  endtask

  task automatic rd(input logic [3:0] b, input bit fresh);
    send(tcbe_pkg::TCBE_CMD_READ, b, 32'h0, 16'h0);
    push(u_nvm.mem[b], 32);
    push(fresh ? crc16(q) : u_nvm.sc[b], 16);
    recv();
  endtask

  // e is the value that the rules say must be programmed
  task automatic wr(input logic [3:0] b, input logic [31:0] v, input logic [31:0] e,
                    input bit bad);
    logic [15:0] c;
    logic [47:0] s;
    bit dr;
    bit act;
    push(v, 32);
    c = crc16(q);
    s = {v, c ^ {15'h0, bad}};
    for (int i = 11; i >= 0; i--)
    begin
      @(posedge core_clk);
      #1;
      sym_valid = 1'b1;
      sym_data = s[i * 4 +: 4];
      sym_last = (i == 0);
      #1;
      chk({cmd_sym_valid, cmd_sym}, {1'b1, s[i * 4 +: 4]});
    end
    @(posedge core_clk);
    #1;
    sym_valid = 1'b0;
    sym_last = 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk(cmd_crc_ok, !bad);
    send(tcbe_pkg::TCBE_CMD_WRITE, b, v, c);
    dr = 0;
    act = 0;
    if (bad)
    begin
      repeat (40 * HC)
      begin
        @(negedge core_clk);
        dr |= cmd_dropped;
        act |= mod_on | nvm_wr;
      end
      chk(dr, 1);
      chk(act, 0);
      q.delete();
    end
    else
    begin
      for (int n = 0; n < 100 && nvm_wr !== 1'b1; n++)
        @(negedge core_clk);
      chk({nvm_blk, nvm_wcrc}, {b, c});
      chk(nvm_wdata, e);
      q.delete();
      push(e, 32);
      push((b == 0 || b == 2) ? crc16(q) : c, 16);
      recv();
    end
  endtask

  initial
  begin
    repeat (12) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    repeat (8) @(negedge core_clk);
    chk(req_ready, 0);
    @(posedge core_clk);
    #1;
    supply_good = 1'b1;
    repeat (4) @(posedge core_clk);
    rd(5, 0);
    rd(0, 1);
    rd(2, 1);
    for (int k = 0; k < 2; k++)
    begin
      d = $random(seed);
      wr(4'(6 + k), d, d, k == 1);
    end
    d = $random(seed);
    wr(0, d, d, 0);
    chk({tsf_mode, bulk_en}, {d[30], d[31]});
    wr(2, 32'h5, 32'h5, 0);
    wr(2, 32'h2, 32'h7, 0);
    wr(0, ~d, {~d[31:30], d[29:0]}, 0);
    chk({tsf_mode, bulk_en}, {~d[30], ~d[31]});
    rd(0, 1);
    rd(2, 1);
    send(tcbe_pkg::TCBE_CMD_BULK, 0, 32'h0, 16'h0);
    push(u_nvm.mem[1], 32);
    for (int i = 3; i < 6; i++)
      push(u_nvm.mem[i], 32);
    while (q.size() > BB - 16)
      void'(q.pop_back());
    push(u_nvm.mem[0], 16);
    recv();
    rd(6, 0);
    rd(7, 0);
    give_verdict();
  end

  initial
  begin
    #(60000 * 40);
    err_total++;
    give_verdict();
  end
endmodule
